// File: peripheral_bus_interface.sv
// Host bus port: decodes select, direction and register select, drives or
// samples the eight-bit data bus, and hands strobes to the internal units.
// Assumes bus pins are asynchronous to CLOCK and are held while phase is high.
//
// Behaviour
// R01 - Bus phase clock times every transfer
// R02 - Act only when selected during high phase
// R03 - Deselected bus causes no access
// R04 - Host decoder selects during high phase
// R05 - Direction high reads, low writes
// R06 - Register select chooses one register
// R07 - Data bus is eight bits wide
// R08 - Drive bus only when selected, reading, high
// R09 - Selected read presents chosen register data
// R10 - Reset returns all registers to defaults
// R11 - Write captured at phase falling edge
// R12 - One-cycle read and write strobes
`timescale 1ns/1ps

module peripheral_bus_interface
    import hostport_pkg::*;
(
    input  wire logic                CLOCK,              // 20 MHz system clock
    input  wire logic                RESETN,             // Asynchronous reset, active low
    input  wire logic                BUS_PHASE,          // Bus phase clock pin
    input  wire logic                SELECT_N,           // Device select, active low
    input  wire logic                READ_NOT_WRITE,     // High read, low write
    input  wire logic [SEL_W-1:0]    REGISTER_SELECT,    // Register select pins
    input  wire logic [DATA_W-1:0]   HOST_DATA_BUS_IN,   // Data bus pin input
    output logic      [DATA_W-1:0]   HOST_DATA_BUS_OUT,  // Data bus pin output
    output logic                     HOST_DATA_BUS_OE,   // Data bus drive enable
    input  wire logic [NREG*DATA_W-1:0] REG_READ_DATA,   // Read data of all registers
    output logic      [NREG-1:0]     READ_STROBE,        // One-cycle read strobe per register
    output logic      [NREG-1:0]     WRITE_STROBE,       // One-cycle write strobe per register
    output logic      [DATA_W-1:0]   WRITE_DATA,         // Data captured by a write
    output logic      [SEL_W-1:0]    ACCESS_SELECT       // Register of the last access
);

    // ======================================================================
    // Synchronisers
    bus_ctl_t          meta_reg;
    bus_ctl_t          sync_reg;
    logic [DATA_W-1:0] data_meta_reg;
    logic [DATA_W-1:0] data_sync_reg;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            meta_reg      <= '{phase: 1'b0, select_n: 1'b1, read_not_write: 1'b1,
                               register_select: SEL_RESET};
            sync_reg      <= '{phase: 1'b0, select_n: 1'b1, read_not_write: 1'b1,
                               register_select: SEL_RESET};
            data_meta_reg <= DATA_RESET;
            data_sync_reg <= DATA_RESET;
        end else begin
            meta_reg      <= '{phase: BUS_PHASE, select_n: SELECT_N,
                               read_not_write: READ_NOT_WRITE,
                               register_select: REGISTER_SELECT};
            sync_reg      <= meta_reg;
            data_meta_reg <= HOST_DATA_BUS_IN;
            data_sync_reg <= data_meta_reg;
        end
    end

    // ======================================================================
    // Cycle decode
    logic         phase_prev_reg;
    logic         selected;
    cycle_state_t state_reg;
    cycle_state_t state_next;

    // Selection counts only inside the high phase, so a select glitch in the
    // low phase cannot start an access.
    assign selected = sync_reg.phase && !sync_reg.select_n;            // R02 R03

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            phase_prev_reg <= 1'b0;
        end else begin
            phase_prev_reg <= sync_reg.phase;                           // R01
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (selected) begin
                    state_next = sync_reg.read_not_write ? ST_READ : ST_WRITE; // R05
                end
            end
            ST_READ, ST_WRITE: begin
                if (!sync_reg.phase) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= ST_IDLE;                                       // R10
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // Register select decode and read data
    logic [SEL_W-1:0]  sel_reg;
    logic [NREG-1:0]   onehot;
    logic [DATA_W-1:0] read_word [NREG];

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sel_reg <= SEL_RESET;
        end else if (state_reg == ST_IDLE && selected) begin
            sel_reg <= sync_reg.register_select;                        // R06
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_dec
            assign onehot[gi]    = (sel_reg == SEL_W'(gi));             // R06
            assign read_word[gi] = REG_READ_DATA[gi*DATA_W +: DATA_W];
        end
    endgenerate

    // ======================================================================
    // Data bus drive
    // Drive is dropped as soon as the phase falls; the extra sync latency is
    // a limitation the host must tolerate as data release time.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            HOST_DATA_BUS_OE  <= 1'b0;
            HOST_DATA_BUS_OUT <= DATA_RESET;
        end else begin
            HOST_DATA_BUS_OE  <= (state_next == ST_READ) && selected
                                 && sync_reg.read_not_write;            // R08
            // First drive cycle reads the synced pins so the bus never shows the
            // register of the previous access.
            HOST_DATA_BUS_OUT <= (state_reg == ST_IDLE) ? read_word[sync_reg.register_select]
                                                        : read_word[sel_reg];    // R09 R07
        end
    end

    // ======================================================================
    // Strobes and write capture
    logic              phase_fall;
    logic [DATA_W-1:0] data_hold_reg;
    assign phase_fall = phase_prev_reg && !sync_reg.phase;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            READ_STROBE   <= STB_RESET;
            WRITE_STROBE  <= STB_RESET;
            WRITE_DATA    <= DATA_RESET;
            ACCESS_SELECT <= SEL_RESET;
            data_hold_reg <= DATA_RESET;
        end else begin
            READ_STROBE   <= (state_reg == ST_READ && phase_fall) ? onehot : STB_RESET;  // R12
            WRITE_STROBE  <= (state_reg == ST_WRITE && phase_fall) ? onehot : STB_RESET; // R12
            if (sync_reg.phase) begin
                data_hold_reg <= data_sync_reg;
            end
            if (state_reg == ST_WRITE && phase_fall) begin
                WRITE_DATA <= data_hold_reg;                            // R11
            end
            if (state_reg != ST_IDLE && phase_fall) begin
                ACCESS_SELECT <= sel_reg;
            end
        end
    end

    // ======================================================================
    // Checks
    // All checks watch synchronised state, so they lag the pins by two edges.
    drive_only_read_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R08
        HOST_DATA_BUS_OE |-> $past(selected) && $past(sync_reg.read_not_write))
        else $error("bus driven outside a selected read");
    deselect_drive_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R08
        !selected |=> !HOST_DATA_BUS_OE)
        else $error("bus driven while not selected");
    idle_no_strobe_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R03
        (state_reg == ST_IDLE) |=> (WRITE_STROBE == STB_RESET))
        else $error("write strobe without an access");
    strobe_single_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R12
        (WRITE_STROBE != STB_RESET) |=> (WRITE_STROBE == STB_RESET))
        else $error("write strobe longer than one cycle");
    rstrobe_single_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R12
        (READ_STROBE != STB_RESET) |=> (READ_STROBE == STB_RESET))
        else $error("read strobe longer than one cycle");
    strobe_onehot_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R06
        $onehot0(WRITE_STROBE | READ_STROBE))
        else $error("more than one register strobed");
    write_dir_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R05
        (WRITE_STROBE != STB_RESET) |-> $past(state_reg) == ST_WRITE)
        else $error("write strobe in a read cycle");
    read_dir_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R05
        (READ_STROBE != STB_RESET) |-> $past(state_reg) == ST_READ)
        else $error("read strobe in a write cycle");
    write_data_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R11
        (WRITE_STROBE != STB_RESET) |-> WRITE_DATA == $past(data_hold_reg))
        else $error("write data not the captured bus value");
    first_data_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R09
        $rose(HOST_DATA_BUS_OE) |-> HOST_DATA_BUS_OUT == $past(read_word[sync_reg.register_select]))
        else $error("first driven byte not from the selected register");
    read_select_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R09
        (HOST_DATA_BUS_OE && $past(HOST_DATA_BUS_OE))
        |-> HOST_DATA_BUS_OUT == $past(read_word[sel_reg]))
        else $error("read data not from the selected register");
    phase_low_off_a: assert property (@(posedge CLOCK) disable iff (!RESETN) // R01
        !sync_reg.phase |=> !HOST_DATA_BUS_OE)
        else $error("bus driven in low phase");

    read_seen_c:  cover property (@(posedge CLOCK) disable iff (!RESETN) READ_STROBE != STB_RESET);
    write_seen_c: cover property (@(posedge CLOCK) disable iff (!RESETN) WRITE_STROBE[15]);
    drive_seen_c: cover property (@(posedge CLOCK) disable iff (!RESETN) $rose(HOST_DATA_BUS_OE));
    first_reg_c:  cover property (@(posedge CLOCK) disable iff (!RESETN) READ_STROBE[0]);
    deselect_c:   cover property (@(posedge CLOCK) disable iff (!RESETN)
        sync_reg.phase && sync_reg.select_n);

endmodule : peripheral_bus_interface

// File: hostport_pkg.sv
// Shared constants and carriers for the host bus port of the peripheral adapter.
// Assumes a single 20 MHz system clock; the bus phase clock arrives as a pin.
package hostport_pkg;

    // ======================================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int SEL_W  = 4;
    localparam int NREG   = 16;

    // ======================================================================
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [SEL_W-1:0]  SEL_RESET  = 4'h0;
    localparam logic [NREG-1:0]   STB_RESET  = 16'h0000;

    // ======================================================================
    // Timing
    localparam int CLOCK_HZ = 20_000_000;

    // Sampled host-side control, after synchronisation
    typedef struct packed {
        logic              phase;
        logic              select_n;
        logic              read_not_write;
        logic [SEL_W-1:0]  register_select;
    } bus_ctl_t;

    typedef enum {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } cycle_state_t;

endpackage : hostport_pkg

// File: host_bus_model.sv
// Host side model: bus phase clock, address decoder select and the data wire.
// Assumes the bench calls cycle() and the device drives only while its enable is high.
`timescale 1ns/1ps

module host_bus_model
    import hostport_pkg::*;
(
    input  wire logic              clk,      // System clock
    input  wire logic              dev_oe,   // Device drive enable
    input  wire logic [DATA_W-1:0] dev_out,  // Device drive value
    output logic                   phase,    // Bus phase clock
    output logic                   select_n, // Decoded device select
    output logic                   rnw,      // Direction, high read
    output logic [SEL_W-1:0]       rsel,     // Register select
    output logic [DATA_W-1:0]      bus       // Resolved data bus level
);
    logic              host_en = 1'b0;
    logic [DATA_W-1:0] host_dat = 8'h00;
    logic [DATA_W-1:0] last = 8'h00;

    // ==========================================================
    // Wire
    // No pull-up: a released bus shows the inverse of the last driven byte,
    // so a stale byte never passes for fresh data
    assign bus = dev_oe ? dev_out : (host_en ? host_dat : ~last);
    always @(posedge clk) begin
        if (dev_oe || host_en) begin
            last <= bus;
        end
    end
    initial begin
        phase    = 1'b0;
        select_n = 1'b1;
        rnw      = 1'b1;
        rsel     = 4'h0;
    end

    // ==========================================================
    // One bus cycle: 7 clocks high phase, 4 low
    task automatic cycle(input logic sel_n, input logic dir, input logic [SEL_W-1:0] k,
                         input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
        @(posedge clk);
        phase    <= 1'b1;
        select_n <= sel_n;
        rnw      <= dir;
        rsel     <= k;
        host_en  <= !dir;
        host_dat <= wd;
        repeat (7) @(posedge clk);
        rd = bus;
        phase    <= 1'b0;
        select_n <= 1'b1;
        host_en  <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : cycle
endmodule : host_bus_model

// File: testbench.sv
// Self-checking bench for the host bus port, driven by the host bus model.
// Assumes one 20 MHz clock; internal units are stood in for by a fixed byte pattern.
`timescale 1ns/1ps

module testbench
    import hostport_pkg::*;
;
    logic                   clock = 1'b0;
    logic                   resetn = 1'b0;
    logic                   phase, select_n, rnw, oe, oe_seen;
    logic [SEL_W-1:0]       rsel, asel;
    logic [DATA_W-1:0]      bus, dout, wdata, rd, keep;
    logic [NREG*DATA_W-1:0] reg_data;
    logic [NREG-1:0]        rstb, wstb, racc, wacc, hot;
    int                     error_cnt = 0;
    int                     compares = 0;
    int                     pulses = 0;
    int                     cycles = 0;

    host_bus_model host_u (.clk(clock), .dev_oe(oe), .dev_out(dout), .phase(phase),
        .select_n(select_n), .rnw(rnw), .rsel(rsel), .bus(bus));
    peripheral_bus_interface dut_u (.CLOCK(clock), .RESETN(resetn), .BUS_PHASE(phase),
        .SELECT_N(select_n), .READ_NOT_WRITE(rnw), .REGISTER_SELECT(rsel),
        .HOST_DATA_BUS_IN(bus), .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe),
        .REG_READ_DATA(reg_data), .READ_STROBE(rstb), .WRITE_STROBE(wstb),
        .WRITE_DATA(wdata), .ACCESS_SELECT(asel));

    // ==========================================================
    // Clock, monitor and timeout
    always #25 clock = ~clock;
    always @(posedge clock) begin
        racc    = racc | rstb;
        wacc    = wacc | wstb;
        pulses  = pulses + int'((rstb | wstb) != '0);
        oe_seen = oe_seen | oe;
        cycles  = cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end

    function automatic logic [DATA_W-1:0] pat(input int n);
        return 8'h3C ^ DATA_W'(n * 17);
    endfunction : pat

    task automatic check(input logic ok, input string what);
        compares = compares + 1;
        if (ok !== 1'b1) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    task automatic access(input logic sel_n, input logic dir, input int k,
                          input logic [DATA_W-1:0] wd);
        @(posedge clock);
        #1;
        racc    = '0;
        wacc    = '0;
        pulses  = 0;
        oe_seen = 1'b0;
        hot     = NREG'(1) << k;
        host_u.cycle(sel_n, dir, SEL_W'(k), wd, rd);
        repeat (4) @(posedge clock);
        #1;
    endtask : access

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check({oe, dout, rstb, wstb, wdata, asel} === '0, "reset values");
        @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        $display("test reset done");
    endtask : t_reset

    task automatic t_write();
        for (int k = 0; k < NREG; k++) begin
            access(1'b0, 1'b0, k, 8'hC3 ^ DATA_W'(k));
            check(wacc === hot && racc === '0 && pulses == 1, "write strobe");
            check(wdata === (8'hC3 ^ DATA_W'(k)), "write data");
            check(asel === SEL_W'(k) && !oe_seen, "write select or drive");
        end
        $display("test write done");
    endtask : t_write

    task automatic t_read();
        for (int k = NREG - 1; k >= 0; k--) begin
            access(1'b0, 1'b1, k, 8'h00);
            check(rd === pat(k) && oe_seen, "read data");
            check(racc === hot && wacc === '0 && pulses == 1, "read strobe");
            check(asel === SEL_W'(k), "read select");
        end
        $display("test read done");
    endtask : t_read

    task automatic t_deselect();
        keep = wdata;
        access(1'b1, 1'b0, 3, 8'hFF);
        check(racc === '0 && wacc === '0 && wdata === keep, "deselected write");
        access(1'b1, 1'b1, 9, 8'h00);
        check(!oe_seen && pulses == 0 && asel === 4'h0, "deselected read");
        $display("test deselect done");
    endtask : t_deselect

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        for (int n = 0; n < NREG; n++) reg_data[n*DATA_W +: DATA_W] = pat(n);
        t_reset();
        t_write();
        t_read();
        t_deselect();
        t_reset();
        report_and_stop();
    end
endmodule : testbench
